/* hw/reset_cause_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock
// Notes: definitions only
`ifndef RESET_CAUSE_DEFINES_SVH
`define RESET_CAUSE_DEFINES_SVH
`define CLK_FREQ_MHZ 20
`define RCC_ADDR 12'h000
`define RCC_PRIO_BIT 7
`define RCC_SOFTBO_BIT 6
`define RCC_SWRST_BIT 4
`define RCC_WDEXP_BIT 3
`define RCC_SLEEP_BIT 2
`define RCC_PWRON_BIT 1
`define RCC_BROWN_BIT 0
`define RCC_RESET_VAL 8'h5C
`define BO_MODE_OFF 2'h0
`define BO_MODE_SOFT 2'h1
`define BO_MODE_NOSLEEP 2'h2
`define BO_MODE_ON 2'h3
`define PWRUP_TICKS 2048
`define OSC_START_TICKS 1024
`define PLL_LOCK_TIME_US 2000
`define PLL_LOCK_CYCLES (`PLL_LOCK_TIME_US * `CLK_FREQ_MHZ)
`define PIN_FILTER_TIME_NS 250
`define PIN_FILTER_CYCLES ((`PIN_FILTER_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define BO_MIN_TIME_NS 1000
`define BO_MIN_CYCLES ((`BO_MIN_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define SYNC_RESET_VAL 4'h1
`endif

/* hw/reset_cause_pkg.sv */
// Purpose: shared types of the reset controller
// Assumes: nothing
// Notes: types only
package reset_cause_pkg;
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_PWRUP,
    ST_OSCWAIT,
    ST_PLLWAIT,
    ST_RUN
  } seq_state_e;

  typedef struct packed {
    logic ext_reset_pin_enable;
    logic powerup_delay_off;
    logic [1:0] brownout_mode_field;
    logic [1:0] brownout_threshold_sel;
    logic crystal_mode;
    logic pll_mode;
  } config_word_two_low_s;

  typedef struct packed {
    logic reset_instr;
    logic watchdog_timeout;
    logic watchdog_clear_instr;
    logic sleep_instr;
    logic stack_reset;
    logic osc_stop_wake;
  } core_events_s;
endpackage : reset_cause_pkg

/* hw/level_filter.sv */
// Purpose: ignores level changes shorter than CYCLES clocks
// Assumes: input already synchronised
// Notes: output changes once the input has held for CYCLES clocks
`timescale 1ns/100ps
`default_nettype none
module level_filter #(
  parameter int CYCLES = 5,
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // level
  input wire logic level_in,
  output logic level_q
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] cnt_q;

  if (CYCLES < 1) begin : g_bad
    $error("level_filter needs CYCLES of at least one");
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      level_q <= RESET_LEVEL;
    end else if (level_in == level_q) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      level_q <= level_in;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : level_filter
`default_nettype wire

/* hw/startup_counter.sv */
// Purpose: counts LIMIT ticks after clear falls, then flags done
// Assumes: tick is a one-cycle pulse or held high, in the clk domain
// Notes: done stays set until clear
`timescale 1ns/100ps
`default_nettype none
module startup_counter #(
  parameter int LIMIT = 2048
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic clear,
  input wire logic tick,
  output logic done_q
);
  localparam int W = $clog2(LIMIT);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);
  logic [W-1:0] cnt_q;

  if (LIMIT < 2) begin : g_bad
    $error("startup_counter needs LIMIT of at least two");
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (clear) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (tick && !done_q) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == LAST) begin
        done_q <= 1'b1;
      end
    end
  end
endmodule : startup_counter
`default_nettype wire

/* hw/reset_cause_and_brownout_ctrl.sv */
// Purpose: merges pin, power-on and brown-out resets with the start-up
//   timers into one core reset, and keeps the reset cause register
// Assumes: resetn is the power-on pulse; config and core events are
//   on clk; pins and oscillators are asynchronous
// Notes: oscillator inputs must stay below a quarter of clk
`timescale 1ns/100ps
`default_nettype none
`include "reset_cause_defines.svh"

module reset_cause_and_brownout_ctrl #(
  parameter int PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // pins and analog monitors
  input wire logic ext_reset_pin,
  input wire logic vdd_below_threshold,
  input wire logic low_freq_internal_osc,
  input wire logic osc_in,
  // configuration and core
  input wire reset_cause_pkg::config_word_two_low_s cfg,
  input wire reset_cause_pkg::core_events_s events,
  input wire logic sleep_mode,
  // outputs to the device
  output logic core_resetn,
  output logic clock_stable,
  output logic interrupt_priority_enable,
  output logic brownout_detector_enable,
  output logic [1:0] brownout_threshold_sel,
  output logic ext_pin_digital_value
);
  reset_cause_pkg::seq_state_e state_q;
  reset_cause_pkg::seq_state_e state_d;
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic lf_prev_q;
  logic osc_prev_q;
  logic lf_tick;
  logic osc_tick;
  logic pin_level;
  logic vdd_low;
  logic pin_rst;
  logic pin_rst_q;
  logic bo_en_d;
  logic bo_low;
  logic bo_low_q;
  logic soft_rst;
  logic hold_src;
  logic full_seq_q;
  logic waking_q;
  logic pwrup_done;
  logic osc_done;
  logic pll_done;
  logic after_pwrup;
  logic prio_q;
  logic softbo_q;
  logic swrst_q;
  logic wdexp_q;
  logic sleepf_q;
  logic pwron_q;
  logic brown_q;
  logic softbo_eff;
  logic [7:0] rcc_view;
  logic accept;
  logic hit;
  logic wr_q;
  reset_cause_pkg::seq_state_e after_osc;
  reset_cause_pkg::seq_state_e first_timer;

  localparam logic [7:0] rst_val = `RCC_RESET_VAL;

  // two flip-flops on every asynchronous input: pin, monitor, oscillators
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= `SYNC_RESET_VAL;
      sync_q <= `SYNC_RESET_VAL;
    end else begin
      meta_q <= {osc_in, low_freq_internal_osc, vdd_below_threshold, ext_reset_pin};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lf_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      lf_prev_q <= sync_q[2];
      osc_prev_q <= sync_q[3];
    end
  end

  assign lf_tick = sync_q[2] && !lf_prev_q;
  assign osc_tick = sync_q[3] && !osc_prev_q;

  // short low pulses on the pin never reach the reset path
  level_filter #(
    .CYCLES(`PIN_FILTER_CYCLES),
    .RESET_LEVEL(1'b1)
  ) u_pin_filter (
    .clk(clk),
    .resetn(resetn),
    .level_in(sync_q[0]),
    .level_q(pin_level)
  );

  // dips shorter than the minimum duration are not qualified
  level_filter #(
    .CYCLES(`BO_MIN_CYCLES),
    .RESET_LEVEL(1'b0)
  ) u_brown_filter (
    .clk(clk),
    .resetn(resetn),
    .level_in(sync_q[1]),
    .level_q(vdd_low)
  );

  // the pin is only ever sampled; this block has no drive onto it
  assign pin_rst = cfg.ext_reset_pin_enable && !pin_level;

  always_comb begin
    case (cfg.brownout_mode_field)
      `BO_MODE_OFF: bo_en_d = 1'b0;
      `BO_MODE_SOFT: bo_en_d = softbo_q;
      `BO_MODE_NOSLEEP: bo_en_d = !sleep_mode;
      `BO_MODE_ON: bo_en_d = 1'b1;
      default: bo_en_d = 1'b0;
    endcase
  end

  assign bo_low = brownout_detector_enable && vdd_low;
  assign soft_rst = events.reset_instr || events.stack_reset ||
                    (events.watchdog_timeout && !sleep_mode);
  assign hold_src = pin_rst || bo_low || soft_rst;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_rst_q <= 1'b0;
      bo_low_q <= 1'b0;
    end else begin
      pin_rst_q <= pin_rst;
      bo_low_q <= bo_low;
    end
  end

  // start-up timers; each runs only while its state is current
  startup_counter #(
    .LIMIT(`PWRUP_TICKS)
  ) u_pwrup_timer (
    .clk(clk),
    .resetn(resetn),
    .clear(state_q != reset_cause_pkg::ST_PWRUP),
    .tick(lf_tick),
    .done_q(pwrup_done)
  );

  startup_counter #(
    .LIMIT(`OSC_START_TICKS)
  ) u_osc_timer (
    .clk(clk),
    .resetn(resetn),
    .clear(state_q != reset_cause_pkg::ST_OSCWAIT),
    .tick(osc_tick),
    .done_q(osc_done)
  );

  startup_counter #(
    .LIMIT(PLL_LOCK_CYCLES)
  ) u_pll_timer (
    .clk(clk),
    .resetn(resetn),
    .clear(state_q != reset_cause_pkg::ST_PLLWAIT),
    .tick(1'b1),
    .done_q(pll_done)
  );

  // crystal modes wait for the oscillator; PLL mode adds the lock wait
  assign after_osc = cfg.pll_mode ? reset_cause_pkg::ST_PLLWAIT
                                  : reset_cause_pkg::ST_HOLD;
  assign first_timer = cfg.crystal_mode ? reset_cause_pkg::ST_OSCWAIT
                                        : after_osc;

  // power-up timer depends only on its own bit, not on brown-out mode
  assign after_pwrup = !cfg.powerup_delay_off;

  always_comb begin
    state_d = state_q;
    case (state_q)
      reset_cause_pkg::ST_HOLD: begin
        if (hold_src) begin
          state_d = reset_cause_pkg::ST_HOLD;
        end else if (!full_seq_q) begin
          state_d = reset_cause_pkg::ST_RUN;
        end else if (after_pwrup) begin
          state_d = reset_cause_pkg::ST_PWRUP;
        end else if (first_timer == reset_cause_pkg::ST_HOLD) begin
          state_d = reset_cause_pkg::ST_RUN;
        end else begin
          state_d = first_timer;
        end
      end
      reset_cause_pkg::ST_PWRUP: begin
        if (bo_low) begin
          state_d = reset_cause_pkg::ST_HOLD;
        end else if (pwrup_done) begin
          state_d = first_timer;
        end
      end
      reset_cause_pkg::ST_OSCWAIT: begin
        if (bo_low || (waking_q && hold_src)) begin
          state_d = reset_cause_pkg::ST_HOLD;
        end else if (osc_done) begin
          state_d = waking_q && !cfg.pll_mode ? reset_cause_pkg::ST_RUN
                                              : after_osc;
        end
      end
      reset_cause_pkg::ST_PLLWAIT: begin
        if (bo_low || (waking_q && hold_src)) begin
          state_d = reset_cause_pkg::ST_HOLD;
        end else if (pll_done) begin
          state_d = waking_q ? reset_cause_pkg::ST_RUN
                             : reset_cause_pkg::ST_HOLD;
        end
      end
      reset_cause_pkg::ST_RUN: begin
        if (hold_src) begin
          state_d = reset_cause_pkg::ST_HOLD;
        end else if (events.osc_stop_wake && cfg.crystal_mode) begin
          state_d = reset_cause_pkg::ST_OSCWAIT;
        end
      end
      default: state_d = reset_cause_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= reset_cause_pkg::ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // a full sequence is owed after power-on and after each brown-out
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      full_seq_q <= 1'b1;
    end else if (bo_low) begin
      full_seq_q <= 1'b1;
    end else if (state_q != reset_cause_pkg::ST_HOLD &&
                 state_d == reset_cause_pkg::ST_HOLD) begin
      full_seq_q <= 1'b0;
    end
  end

  // a wake wait keeps the core out of reset but marks the clock unstable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waking_q <= 1'b0;
    end else if (state_d == reset_cause_pkg::ST_HOLD ||
                 state_d == reset_cause_pkg::ST_RUN) begin
      waking_q <= 1'b0;
    end else if (state_q == reset_cause_pkg::ST_RUN) begin
      waking_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_resetn <= 1'b0;
      clock_stable <= 1'b0;
    end else begin
      core_resetn <= state_d == reset_cause_pkg::ST_RUN ||
                     ((waking_q || state_q == reset_cause_pkg::ST_RUN) &&
                      state_d != reset_cause_pkg::ST_HOLD);
      clock_stable <= state_d == reset_cause_pkg::ST_RUN;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brownout_detector_enable <= 1'b0;
      brownout_threshold_sel <= 2'h0;
      ext_pin_digital_value <= 1'b1;
    end else begin
      brownout_detector_enable <= bo_en_d;
      brownout_threshold_sel <= cfg.brownout_threshold_sel;
      ext_pin_digital_value <= pin_level;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  assign accept = hsel && hready && htrans[1];
  assign hit = haddr[11:0] == `RCC_ADDR;
  assign softbo_eff = softbo_q &&
                      cfg.brownout_mode_field == `BO_MODE_SOFT;
  assign rcc_view = {prio_q, softbo_eff, 1'b0, swrst_q,
                     wdexp_q, sleepf_q, pwron_q, brown_q};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_q <= accept && hwrite && hit && hsize == 3'h2;
      hrdata <= (accept && !hwrite && hit) ? {24'h00_0000, rcc_view}
                                           : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // software writes first, hardware events after, so an event wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prio_q <= rst_val[`RCC_PRIO_BIT];
      softbo_q <= rst_val[`RCC_SOFTBO_BIT];
      swrst_q <= rst_val[`RCC_SWRST_BIT];
      wdexp_q <= rst_val[`RCC_WDEXP_BIT];
      sleepf_q <= rst_val[`RCC_SLEEP_BIT];
      pwron_q <= rst_val[`RCC_PWRON_BIT];
      brown_q <= rst_val[`RCC_BROWN_BIT];
    end else begin
      if (wr_q) begin
        prio_q <= hwdata[`RCC_PRIO_BIT];
        softbo_q <= hwdata[`RCC_SOFTBO_BIT];
        swrst_q <= hwdata[`RCC_SWRST_BIT];
        pwron_q <= hwdata[`RCC_PWRON_BIT];
        brown_q <= hwdata[`RCC_BROWN_BIT];
      end
      if (bo_low && !bo_low_q) begin
        brown_q <= 1'b0;
        swrst_q <= 1'b1;
        wdexp_q <= 1'b1;
        sleepf_q <= 1'b1;
      end
      if (pin_rst && !pin_rst_q && sleep_mode) begin
        wdexp_q <= 1'b1;
        sleepf_q <= 1'b0;
      end
      if (events.reset_instr) begin
        swrst_q <= 1'b0;
      end
      if (events.sleep_instr) begin
        wdexp_q <= 1'b1;
        sleepf_q <= 1'b0;
      end
      if (events.watchdog_clear_instr) begin
        wdexp_q <= 1'b1;
        sleepf_q <= 1'b1;
      end
      if (events.watchdog_timeout) begin
        wdexp_q <= 1'b0;
        if (sleep_mode) begin
          sleepf_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_priority_enable <= 1'b0;
    end else begin
      interrupt_priority_enable <= prio_q;
    end
  end
endmodule : reset_cause_and_brownout_ctrl
`default_nettype wire

/* tb/reset_cause_monitor.sv */
// Purpose: port-level timing checks of the reset controller
// Assumes: register at offset 0, word writes only
// Notes: bound to every instance of the controller
`timescale 1ns/100ps
`default_nettype none
module reset_cause_monitor #(
  parameter int PLL_LOCK_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // pins, configuration and core
  input wire logic ext_reset_pin,
  input wire logic vdd_below_threshold,
  input wire reset_cause_pkg::config_word_two_low_s cfg,
  input wire reset_cause_pkg::core_events_s events,
  input wire logic sleep_mode,
  // controller outputs
  input wire logic core_resetn,
  input wire logic interrupt_priority_enable,
  input wire logic brownout_detector_enable,
  input wire logic [1:0] brownout_threshold_sel,
  input wire logic ext_pin_digital_value
);
  logic rd_q;
  logic wr_q;
  logic live_q;
  logic [4:0] bo_cnt_q;
  wire logic hit = hsel && hready && htrans[1] && haddr == 32'h0000_0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      rd_q <= hit && !hwrite;
      wr_q <= hit && hwrite && hsize == 3'h2;
    end
  end

  // saturating run length of a sag the detector can see
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bo_cnt_q <= 5'h00;
    end else if (!(vdd_below_threshold && brownout_detector_enable)) begin
      bo_cnt_q <= 5'h00;
    end else if (bo_cnt_q != 5'h1F) begin
      bo_cnt_q <= bo_cnt_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  // checks start one edge after release, so no attempt spans it
  default disable iff (!live_q);

  AST_PRIO_FOLLOWS: assert property (
    wr_q |=> ##1 interrupt_priority_enable == $past(hwdata[7], 2))
    else $error("priority enable differs from written bit 7");
  AST_BIT5_ZERO: assert property (
    rd_q |-> hrdata[5] == 1'b0 && hrdata[31:8] == 24'h000000)
    else $error("unimplemented bits read nonzero");
  AST_SOFT_MASK: assert property (
    rd_q && cfg.brownout_mode_field != 2'h1 |-> !hrdata[6])
    else $error("soft enable visible outside mode 01");
  AST_MODE_DECODE: assert property (
    cfg.brownout_mode_field != 2'h1 |=> brownout_detector_enable ==
      ($past(cfg.brownout_mode_field) == 2'h3 ||
       ($past(cfg.brownout_mode_field) == 2'h2 && !$past(sleep_mode))))
    else $error("detector enable does not match mode field");
  AST_THRESH_COPY: assert property (
    1'b1 |=> brownout_threshold_sel == $past(cfg.brownout_threshold_sel))
    else $error("threshold output not from configuration");
  AST_PIN_RESET: assert property (
    (cfg.ext_reset_pin_enable && !ext_reset_pin) [*8] |-> ##4 !core_resetn)
    else $error("held pin did not reset the core");
  AST_PIN_PLAIN: assert property (
    (!ext_reset_pin) [*8] |-> ##3 !ext_pin_digital_value)
    else $error("pin level not seen as digital input");
  AST_SOFT_RESET: assert property (
    events.reset_instr && core_resetn |=> !core_resetn ##1 core_resetn)
    else $error("reset instruction pulse wrong");
  AST_BO_HOLD: assert property (
    bo_cnt_q >= 5'h1A |-> !core_resetn)
    else $error("long sag did not hold reset");
endmodule : reset_cause_monitor

bind reset_cause_and_brownout_ctrl reset_cause_monitor #(
  .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)
) u_mon (
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .ext_reset_pin(ext_reset_pin), .vdd_below_threshold(vdd_below_threshold),
  .cfg(cfg), .events(events), .sleep_mode(sleep_mode), .core_resetn(core_resetn),
  .interrupt_priority_enable(interrupt_priority_enable),
  .brownout_detector_enable(brownout_detector_enable),
  .brownout_threshold_sel(brownout_threshold_sel),
  .ext_pin_digital_value(ext_pin_digital_value)
);
`default_nettype wire

/* tb/supply_pin_model.sv */
// Purpose: external reset pin, supply monitor and free-running oscillators
// Assumes: pin and sag requests are counted in clk cycles
// Notes: oscillators run free with no phase relation to clk
`timescale 1ns/100ps
`default_nettype none
module supply_pin_model #(
  parameter int SLOW_HALF_NS = 203,
  parameter int OSC_HALF_NS = 151
) (
  // clock
  input wire logic clk,
  // pins and monitors
  output var logic ext_reset_pin,
  output var logic vdd_below_threshold,
  output var logic low_freq_internal_osc,
  output var logic osc_in
);
  initial begin
    ext_reset_pin = 1'b1;
    vdd_below_threshold = 1'b0;
    low_freq_internal_osc = 1'b0;
    osc_in = 1'b0;
  end
  always #(SLOW_HALF_NS) low_freq_internal_osc = !low_freq_internal_osc;
  always #(OSC_HALF_NS) osc_in = !osc_in;

  // only the far side ever pulls the pin low
  task automatic pin_low(input int n);
    @(posedge clk);
    ext_reset_pin <= 1'b0;
    repeat (n) @(posedge clk);
    ext_reset_pin <= 1'b1;
  endtask : pin_low

  task automatic sag(input int n);
    @(posedge clk);
    vdd_below_threshold <= 1'b1;
    repeat (n) @(posedge clk);
    vdd_below_threshold <= 1'b0;
  endtask : sag
endmodule : supply_pin_model
`default_nettype wire

/* tb/reset_cause_and_brownout_ctrl_tb.sv */
// Purpose: register, reset source and power-up timer tests
// Assumes: power-up delay bypassed except in the timer test
// Notes: slow oscillator period sets the expected timer length
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_brownout_ctrl_tb;
  localparam int SLOW_HALF_NS = 203;
  localparam int PWRUP_MIN = 2047 * 2 * SLOW_HALF_NS / 50;
  localparam int OSC_MIN = 1023 * 2 * 151 / 50;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, core_resetn, clock_stable, interrupt_priority_enable;
  logic [31:0] hrdata;
  logic ext_reset_pin, vdd_below_threshold, low_freq_internal_osc, osc_in;
  reset_cause_pkg::config_word_two_low_s cfg = '{1'b1, 1'b1, 2'h1, 2'h2, 1'b0, 1'b0};
  reset_cause_pkg::core_events_s events = '0;
  logic sleep_mode = 1'b0;
  logic brownout_detector_enable, ext_pin_digital_value;
  logic [1:0] brownout_threshold_sel;
  logic [31:0] rd;
  int n_errors = 0;
  int checks = 0;
  int n_low = 0;
  int base = 0;
  int cnt;
  int evs[5] = '{2, 3, 4, 1, 5};
  logic [7:0] exps[5] = '{8'h1B, 8'h1F, 8'h17, 8'h17, 8'h07};
  logic rsts[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  always #25 clk = !clk;
  always @(posedge clk) if (core_resetn === 1'b0) n_low <= n_low + 1;

  reset_cause_and_brownout_ctrl #(.PLL_LOCK_CYCLES(8)) u_dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ext_reset_pin(ext_reset_pin), .vdd_below_threshold(vdd_below_threshold),
    .low_freq_internal_osc(low_freq_internal_osc), .osc_in(osc_in), .cfg(cfg),
    .events(events), .sleep_mode(sleep_mode), .core_resetn(core_resetn),
    .clock_stable(clock_stable), .interrupt_priority_enable(interrupt_priority_enable),
    .brownout_detector_enable(brownout_detector_enable),
    .brownout_threshold_sel(brownout_threshold_sel),
    .ext_pin_digital_value(ext_pin_digital_value));
  supply_pin_model #(.SLOW_HALF_NS(SLOW_HALF_NS), .OSC_HALF_NS(151)) u_sp (
    .clk(clk), .ext_reset_pin(ext_reset_pin), .vdd_below_threshold(vdd_below_threshold),
    .low_freq_internal_osc(low_freq_internal_osc), .osc_in(osc_in));

  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_flag

  // hreadyout is read before the edge's own updates land
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : xfer

  task automatic chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    cmp_word(rd, exp);
    cmp_flag(hresp, 1'b0);
  endtask : chk

  task automatic wait_up(input int n);
    repeat (n) if (core_resetn !== 1'b1) @(posedge clk);
    cmp_flag(core_resetn, 1'b1);
  endtask : wait_up

  task automatic fire(input int i);
    base = n_low;
    @(posedge clk);
    events <= reset_cause_pkg::core_events_s'(6'h01 << i);
    @(posedge clk);
    events <= '0;
    repeat (6) @(posedge clk);
  endtask : fire

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    wait_up(100);
    chk(32'h0, 32'h5C);
    xfer(1'b1, 32'h4, 32'hFF);
    chk(32'h4, 32'h0);
    cmp_flag(brownout_detector_enable, 1'b1);
    xfer(1'b1, 32'h0, 32'hFF);
    chk(32'h0, 32'hDF);
    cmp_flag(interrupt_priority_enable, 1'b1);
    xfer(1'b1, 32'h0, 32'h40);
    chk(32'h0, 32'h4C);
    hsize <= 3'h0;
    xfer(1'b1, 32'h0, 32'hFF);
    hsize <= 3'h2;
    chk(32'h0, 32'h4C);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      cfg.brownout_mode_field <= i[1:0] ^ {i[2], 1'b0};
      cfg.brownout_threshold_sel <= i[1:0];
      sleep_mode <= i[2];
      chk(32'h0, (i == 1) ? 32'h4C : 32'h0C);
      cmp_flag(brownout_detector_enable, i != 0 && i != 4);
      cmp_word({30'h0, brownout_threshold_sel}, {30'h0, i[1:0]});
    end
    @(posedge clk);
    cfg.brownout_mode_field <= 2'h3;
    sleep_mode <= 1'b0;
    xfer(1'b1, 32'h0, 32'h13);
    chk(32'h0, 32'h1F);
    for (int i = 0; i < 5; i++) begin
      fire(evs[i]);
      cmp_flag(n_low != base, rsts[i]);
      chk(32'h0, {24'h0, exps[i]});
    end
    $display("test events done");
    base = n_low;
    u_sp.pin_low(3);
    repeat (20) @(posedge clk);
    cmp_flag(n_low != base, 1'b0);
    u_sp.pin_low(20);
    wait_up(40);
    cmp_flag(n_low != base, 1'b1);
    @(posedge clk);
    cfg.ext_reset_pin_enable <= 1'b0;
    base = n_low;
    u_sp.pin_low(20);
    cmp_flag(ext_pin_digital_value, 1'b0);
    repeat (20) @(posedge clk);
    cmp_flag(n_low != base, 1'b0);
    chk(32'h0, 32'h07);
    $display("test pin done");
    u_sp.sag(5);
    repeat (30) @(posedge clk);
    cmp_flag(n_low != base, 1'b0);
    u_sp.sag(40);
    wait_up(80);
    cmp_flag(n_low != base, 1'b1);
    chk(32'h0, 32'h1E);
    @(posedge clk);
    cfg.brownout_mode_field <= 2'h0;
    base = n_low;
    u_sp.sag(40);
    repeat (40) @(posedge clk);
    cmp_flag(n_low != base, 1'b0);
    @(posedge clk);
    cfg.brownout_mode_field <= 2'h3;
    cfg.powerup_delay_off <= 1'b0;
    u_sp.sag(40);
    repeat (8000) @(posedge clk);
    cmp_flag(core_resetn, 1'b0);
    u_sp.sag(40);
    cnt = 0;
    while (core_resetn !== 1'b1 && cnt < 20000) begin
      @(posedge clk);
      cnt++;
    end
    cmp_flag(cnt >= PWRUP_MIN && cnt < PWRUP_MIN + 80, 1'b1);
    cfg.powerup_delay_off <= 1'b1;
    cfg.crystal_mode <= 1'b1;
    cfg.pll_mode <= 1'b1;
    u_sp.sag(40);
    cnt = 0;
    while (core_resetn !== 1'b1 && cnt < 20000) begin
      @(posedge clk);
      cnt++;
    end
    cmp_flag(cnt >= OSC_MIN && cnt < OSC_MIN + 80, 1'b1);
    fire(0);
    cmp_flag(n_low != base || clock_stable, 1'b0);
    cnt = 0;
    while (clock_stable !== 1'b1 && cnt < 20000) begin
      @(posedge clk);
      cnt++;
    end
    cmp_flag(clock_stable && cnt > OSC_MIN - 80 && n_low == base, 1'b1);
    $display("test timers done");
    stop_test();
  end

  // whole run is about 37500 cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule : reset_cause_and_brownout_ctrl_tb
`default_nettype wire
